// ===== rtl/bdsp_ctrl.sv
// Memory controller end: makes the K clock enable, brings the DLL up,
// issues one burst command per two memory cycles and gathers read beats.
// Assumes the device on the link samples everything on clk.
`timescale 1ns/10ps
module bdsp_ctrl
  import bdsp_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  sys_rst,
  bdsp_link_if.ctl   link,
  input  wire logic  clockStop,
  input  wire logic  reqValid,
  output logic       reqReady,
  input  wire logic  reqWrite,
  input  bdsp_addr_t reqAddr,
  input  bdsp_burst_t reqWrData,
  input  bdsp_bmask_t reqMask_n,
  output bdsp_burst_t rdData,
  output logic       rdValid,
  output logic       linkReady
);

  typedef enum logic [1:0] {
    CS_DOFF = 2'b00,
    CS_LOCK = 2'b01,
    CS_RUN  = 2'b10,
    CS_STOP = 2'b11
  } bdsp_ctl_state_e;

  // ==========================================================
  // State
  typedef struct packed {
    bdsp_ctl_state_e    state;
    logic [LOCK_W-1:0]  cnt;
    logic               kRun;
    logic               kRise;
    logic               dllOff_n;
    logic               readSel_n;
    logic               writeSel_n;
    bdsp_addr_t         addr;
    logic [CNT_W-1:0]   hold;
    logic [CNT_W-1:0]   quiet;
    bdsp_burst_t        pendBuf;
    bdsp_bmask_t        pendMask;
    logic [1:0]         pendCnt;
    bdsp_burst_t        shBuf;
    bdsp_bmask_t        shMask;
    logic [BEAT_W-1:0]  shLeft;
    bdsp_data_t         dataIn;
    bdsp_mask_t         mask_n;
    bdsp_burst_t        rdBuf;
    logic [BEAT_W-1:0]  rdBeat;
    bdsp_burst_t        rdOut;
    logic               rdValid;
  } bdsp_ctl_state_s;

  bdsp_ctl_state_s st;
  bdsp_ctl_state_s next_st;
  logic            issue;
  logic            idle;

  assign idle = st.hold == '0 && st.pendCnt == '0 && st.shLeft == '0 &&
                st.quiet >= CNT_W'(RD_DONE_CYC);
  assign reqReady = st.state == CS_RUN && st.hold == '0 && st.kRun &&
                    !st.kRise && !clockStop;
  assign issue = reqReady && reqValid;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_st            = st;
    next_st.kRise      = st.kRun && !st.kRise;
    next_st.readSel_n  = 1'b1;
    next_st.writeSel_n = 1'b1;
    next_st.rdValid    = 1'b0;
    next_st.mask_n     = '1;
    if (st.hold != '0)
      next_st.hold = st.hold - 1'b1;
    if (st.quiet < CNT_W'(RD_DONE_CYC))
      next_st.quiet = st.quiet + 1'b1;

    case (st.state)
      CS_DOFF:
      begin
        // Disable pin low for the full reset period before release
        next_st.dllOff_n = 1'b0; // [R6]
        next_st.cnt      = st.cnt + 1'b1;
        if (st.cnt >= LOCK_W'(DOFF_LOW_CYC))
        begin
          next_st.dllOff_n = 1'b1;
          next_st.cnt      = '0;
          next_st.state    = CS_LOCK;
        end
      end
      CS_LOCK:
      begin
        if (st.kRise)
          next_st.cnt = st.cnt + 1'b1; // [R5]
        if (st.kRise && st.cnt == LOCK_W'(DLL_LOCK_KCYC - 1))
          next_st.state = CS_RUN;
      end
      CS_RUN:
      begin
        if (clockStop && idle)
        begin
          next_st.kRun  = 1'b0;
          next_st.kRise = 1'b0;
          next_st.state = CS_STOP;
        end
      end
      CS_STOP:
      begin
        next_st.kRise = 1'b0;
        if (!clockStop)
        begin
          next_st.kRun  = 1'b1; // [R7]
          next_st.cnt   = '0;
          next_st.state = CS_LOCK;
        end
      end
      default:
        next_st.state = CS_DOFF;
    endcase

    if (issue)
    begin
      next_st.addr = reqAddr;
      next_st.hold = CNT_W'(CMD_SPACE_CYC - 1);
      if (reqWrite)
      begin
        next_st.writeSel_n = 1'b0;
        next_st.pendBuf    = reqWrData;
        next_st.pendMask   = reqMask_n; // [R3]
        next_st.pendCnt    = 2'(WR_LAT_CYC);
      end
      else
      begin
        next_st.readSel_n = 1'b0;
        next_st.quiet     = '0;
      end
    end

    // Write beats on the link one memory cycle after the command
    if (st.pendCnt != '0)
      next_st.pendCnt = st.pendCnt - 1'b1;
    if (st.pendCnt == 2'h1)
    begin
      next_st.dataIn = st.pendBuf[DATA_W-1:0];
      next_st.mask_n = st.pendMask[NBYTES-1:0]; // [R3]
      next_st.shBuf  = st.pendBuf >> DATA_W;
      next_st.shMask = st.pendMask >> NBYTES;
      next_st.shLeft = BEAT_LAST;
    end
    else if (st.shLeft != '0)
    begin
      next_st.dataIn = st.shBuf[DATA_W-1:0];
      next_st.mask_n = st.shMask[NBYTES-1:0];
      next_st.shBuf  = st.shBuf >> DATA_W;
      next_st.shMask = st.shMask >> NBYTES;
      next_st.shLeft = st.shLeft - 1'b1;
    end

    // Gather four read beats, beat 0 in the low word
    if (link.dataValid)
    begin
      next_st.rdBuf[st.rdBeat*DATA_W +: DATA_W] = link.dataOut; // [R12]
      next_st.rdBeat = st.rdBeat + 2'h1;
      if (st.rdBeat == BEAT_LAST)
      begin
        next_st.rdOut = next_st.rdBuf;
        next_st.rdValid = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st          <= '0;
      st.kRun     <= 1'b1;
      st.dllOff_n <= 1'b1;
      st.readSel_n  <= 1'b1;
      st.writeSel_n <= 1'b1;
      st.mask_n   <= '1;
      st.quiet    <= CNT_W'(RD_DONE_CYC);
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs; test port held idle, TDO never read or driven [R10]
  assign link.kRise           = st.kRise;
  assign link.kRun            = st.kRun;
  assign link.dllOff_n        = st.dllOff_n;
  assign link.readSel_n       = st.readSel_n;
  assign link.writeSel_n      = st.writeSel_n;
  assign link.addr            = st.addr;
  assign link.dataIn          = st.dataIn;
  assign link.byteWriteMask_n = st.mask_n;
  assign link.tck             = 1'b0; // [R8]
  assign link.tms             = 1'b0;
  assign link.tmsOe           = 1'b0; // [R9]
  assign link.tdi             = 1'b0;
  assign link.tdiOe           = 1'b0; // [R9]
  assign rdData               = st.rdOut;
  assign rdValid              = st.rdValid;
  assign linkReady            = st.state == CS_RUN;

endmodule

// ===== rtl/bdsp_device.sv
// Memory device end: burst-of-four DDR storage, DLL lock model, test port.
// Assumes link inputs are synchronous to clk; kRise marks a rising K edge.
//
// Summary of operation
// R1: Each command moves four beats, counter-addressed.
// R2: Read outputs disable one cycle after idle.
// R3: Per-beat byte masks gate each written byte.
// R4: Read of pending write address gets forwarded data.
// R5: Controller waits 2048 clock cycles for lock.
// R6: DLL reset needs disable low 5 ns.
// R7: Clock static 30 ns resets DLL; relock.
// R8: Unused test clock is tied low.
// R9: Test data and mode inputs pulled high.
// R10: Test data output left undriven outside.
// R11: Power-up puts test port in reset.
// R12: Read data 2.5 cycles later, four beats.
`timescale 1ns/10ps
module bdsp_device
  import bdsp_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  bdsp_link_if.dev  link,
  output logic      dllLocked,
  output logic      tapInReset
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [RD_PIPE-1:0]             rdVld;
    logic [RD_PIPE-1:0][ADDR_W-1:0] rdAdr;
    logic                           rdBusy;
    bdsp_addr_t                     rdAddr;
    logic [BEAT_W-1:0]              rdBeat;
    logic [WR_LAT_CYC-1:0]          wrVld;
    logic [WR_LAT_CYC-1:0][ADDR_W-1:0] wrAdr;
    logic                           wrBusy;
    bdsp_addr_t                     wrAddr;
    logic [BEAT_W-1:0]              wrBeat;
    bdsp_data_t                     dataOut;
    logic                           dataOutEn;
    logic [LOCK_W-1:0]              lockCnt;
    logic                           locked;
    logic [CNT_W-1:0]               stopCnt;
    logic [CNT_W-1:0]               offCnt;
    logic                           tckPrev;
    logic [CNT_W-1:0]               tmsHighCnt;
    logic                           tapReset;
    logic                           bypassBit;
  } bdsp_dev_state_s;

  bdsp_dev_state_s st;
  bdsp_dev_state_s next_st;

  // Storage port signals
  logic                      wrGo;
  logic [ADDR_W+BEAT_W-1:0]  wrA;
  logic                      rdGo;
  logic [ADDR_W+BEAT_W-1:0]  rdA;
  bdsp_data_t                rdWord;

  // Test pins seen through their pull-ups
  logic tmsSeen;
  logic tdiSeen;
  logic tckRise;

  assign tmsSeen = link.tmsOe ? link.tms : 1'b1; // [R9]
  assign tdiSeen = link.tdiOe ? link.tdi : 1'b1; // [R9]
  assign tckRise = link.tck && !st.tckPrev;

  // ==========================================================
  // Storage, one array per byte lane
  genvar b;
  generate
    for (b = 0; b < NBYTES; b++)
    begin : g_lane
      logic [BYTE_W-1:0] lane [DEPTH];
      logic              laneWr;
      logic [BYTE_W-1:0] laneIn;

      assign laneIn = link.dataIn[b*BYTE_W +: BYTE_W];
      assign laneWr = wrGo && !link.byteWriteMask_n[b]; // [R3]

      always_ff @(posedge clk)
      begin
        if (laneWr)
          lane[wrA] <= laneIn; // [R3]
      end

      // Beat being written this tick bypasses the array
      assign rdWord[b*BYTE_W +: BYTE_W] =
        (laneWr && wrA == rdA) ? laneIn : lane[rdA]; // [R4]
    end
  endgenerate

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_st = st;
    wrGo    = 1'b0;
    wrA     = {st.wrAddr, st.wrBeat};
    rdGo    = 1'b0;
    rdA     = {st.rdAddr, st.rdBeat};

    // Command capture on rising K
    next_st.rdVld = {st.rdVld[RD_PIPE-2:0],
                     link.kRise && !link.readSel_n};
    next_st.rdAdr = {st.rdAdr[RD_PIPE-2:0], link.addr};
    next_st.wrVld = {st.wrVld[WR_LAT_CYC-2:0],
                     link.kRise && !link.writeSel_n};
    next_st.wrAdr = {st.wrAdr[WR_LAT_CYC-2:0], link.addr};

    // Write burst: beat 0 one memory cycle after the command
    if (st.wrVld[WR_LAT_CYC-1])
    begin
      wrGo           = 1'b1;
      wrA            = {st.wrAdr[WR_LAT_CYC-1], BEAT_FIRST}; // [R1]
      next_st.wrAddr = st.wrAdr[WR_LAT_CYC-1];
      next_st.wrBeat = BEAT_FIRST + 2'h1;
      next_st.wrBusy = 1'b1;
    end
    else if (st.wrBusy)
    begin
      wrGo           = 1'b1;
      next_st.wrBeat = st.wrBeat + 2'h1; // [R1]
      if (st.wrBeat == BEAT_LAST)
        next_st.wrBusy = 1'b0;
    end

    // Read burst: fetch so beat 0 leaves 2.5 memory cycles late
    if (st.rdVld[RD_PIPE-1])
    begin
      rdGo           = 1'b1;
      rdA            = {st.rdAdr[RD_PIPE-1], BEAT_FIRST}; // [R12]
      next_st.rdAddr = st.rdAdr[RD_PIPE-1];
      next_st.rdBeat = BEAT_FIRST + 2'h1;
      next_st.rdBusy = 1'b1;
    end
    else if (st.rdBusy)
    begin
      rdGo           = 1'b1;
      next_st.rdBeat = st.rdBeat + 2'h1; // [R1]
      if (st.rdBeat == BEAT_LAST)
        next_st.rdBusy = 1'b0;
    end

    // Outputs drop the tick after the last beat if nothing follows
    next_st.dataOutEn = rdGo; // [R2]
    if (rdGo)
      next_st.dataOut = rdWord; // [R12]

    // DLL: disable pin or a stopped clock forces relock
    if (!link.dllOff_n)
    begin
      if (st.offCnt < CNT_W'(DOFF_LOW_CYC))
        next_st.offCnt = st.offCnt + 1'b1;
    end
    else
      next_st.offCnt = '0;

    if (!link.kRun)
    begin
      if (st.stopCnt < CNT_W'(KSTATIC_CYC))
        next_st.stopCnt = st.stopCnt + 1'b1;
    end
    else
      next_st.stopCnt = '0;

    if (next_st.offCnt >= CNT_W'(DOFF_LOW_CYC) ||
        next_st.stopCnt >= CNT_W'(KSTATIC_CYC))
    begin
      next_st.lockCnt = '0; // [R7]
      next_st.locked  = 1'b0;
    end
    else if (link.kRise && !st.locked)
    begin
      next_st.lockCnt = st.lockCnt + 1'b1;
      if (st.lockCnt == LOCK_W'(DLL_LOCK_KCYC - 1))
        next_st.locked = 1'b1;
    end

    // Test port: five high TMS samples reset it
    next_st.tckPrev = link.tck;
    if (tckRise)
    begin
      next_st.bypassBit = tdiSeen;
      if (tmsSeen)
      begin
        if (st.tmsHighCnt < CNT_W'(TAP_RST_EDGES))
          next_st.tmsHighCnt = st.tmsHighCnt + 1'b1;
        if (st.tmsHighCnt >= CNT_W'(TAP_RST_EDGES - 1))
          next_st.tapReset = 1'b1;
      end
      else
      begin
        next_st.tmsHighCnt = '0;
        next_st.tapReset   = 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st          <= '0;
      st.tapReset <= 1'b1; // [R11]
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs
  assign link.dataOut   = st.dataOut;
  assign link.dataOutEn = st.dataOutEn;
  assign link.dataValid = st.dataOutEn;
  assign link.tdo       = st.bypassBit;
  assign link.tdoOe     = !st.tapReset; // [R11]
  assign dllLocked      = st.locked;
  assign tapInReset     = st.tapReset;

endmodule

// ===== rtl/bdsp_link_if.sv
// Pin-level link between memory controller and memory device.
// Two-way test pins carry value plus enable; the device resolves TMS and TDI through its pull-ups.
`timescale 1ns/10ps
interface bdsp_link_if;
  import bdsp_pkg::*;

  logic       kRise;
  logic       kRun;
  logic       dllOff_n;
  logic       readSel_n;
  logic       writeSel_n;
  bdsp_addr_t addr;
  bdsp_data_t dataIn;
  bdsp_mask_t byteWriteMask_n;
  bdsp_data_t dataOut;
  logic       dataOutEn;
  logic       dataValid;
  logic       tck;
  logic       tms;
  logic       tmsOe;
  logic       tdi;
  logic       tdiOe;
  logic       tdo;
  logic       tdoOe;

  modport dev (
    input  kRise, kRun, dllOff_n, readSel_n, writeSel_n, addr, dataIn,
    input  byteWriteMask_n, tck, tms, tmsOe, tdi, tdiOe,
    output dataOut, dataOutEn, dataValid, tdo, tdoOe
  );

  modport ctl (
    output kRise, kRun, dllOff_n, readSel_n, writeSel_n, addr, dataIn,
    output byteWriteMask_n, tck, tms, tmsOe, tdi, tdiOe,
    input  dataOut, dataOutEn, dataValid
  );

endinterface

// ===== rtl/bdsp_pkg.sv
// Shared constants and types for the burst-of-four DDR memory port.
// Assumes one 10 MHz system clock; each memory clock cycle is two ticks.
package bdsp_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W  = 6;
  localparam int BEAT_W  = 2;
  localparam int BURST   = 4;
  localparam int DATA_W  = 18;
  localparam int BYTE_W  = 9;
  localparam int NBYTES  = 2;
  localparam int DEPTH   = 1 << (ADDR_W + BEAT_W);

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICKS_PER_KCYC = 2;
  localparam int DOFF_LOW_NS    = 5;
  localparam int DOFF_LOW_CYC   =
    (DOFF_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int KSTATIC_NS     = 30;
  localparam int KSTATIC_CYC    =
    (KSTATIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_KCYC  = 2048;
  localparam int LOCK_W         = 12;
  localparam int CNT_W          = 4;
  // Read data leaves 2.5 memory cycles after the command
  localparam int RD_LAT_CYC     = 5;
  localparam int RD_PIPE        = RD_LAT_CYC - 1;
  // Write data enters one memory cycle after the command
  localparam int WR_LAT_CYC     = TICKS_PER_KCYC;
  // Least spacing between two commands, in ticks
  localparam int CMD_SPACE_CYC  = BURST;
  // Ticks from a read command until its last beat is out
  localparam int RD_DONE_CYC    = RD_LAT_CYC + BURST;
  // Consecutive high TMS samples that reset the test port
  localparam int TAP_RST_EDGES  = 5;

  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_LAST  = 2'h3;

  typedef logic [ADDR_W-1:0]         bdsp_addr_t;
  typedef logic [DATA_W-1:0]         bdsp_data_t;
  typedef logic [NBYTES-1:0]         bdsp_mask_t;
  typedef logic [BURST*DATA_W-1:0]   bdsp_burst_t;
  typedef logic [BURST*NBYTES-1:0]   bdsp_bmask_t;

endpackage

// ===== sim/bdsp_link_properties.sv
// Checker for the link between memory controller and memory device.
// Assumes one clock domain; sys_rst synchronous, active high.
`timescale 1ns/10ps
module bdsp_link_checker
  import bdsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic kRise,
  input wire logic kRun,
  input wire logic dllOff_n,
  input wire logic readSel_n,
  input wire logic writeSel_n,
  input wire logic dataOutEn,
  input wire logic dataValid,
  input wire logic tck,
  input wire logic tmsOe,
  input wire logic tdiOe,
  input wire logic tdoOe,
  input wire logic dllLocked,
  input wire logic tapInReset
);
  // ==========================================================
  // Helper logic
  logic              rdCmd;
  logic [LOCK_W-1:0] kCnt;

  assign rdCmd = kRise & ~readSel_n;

  // K edges since the last DLL reset cause
  always_ff @(posedge clk)
  begin
    if (sys_rst || !dllOff_n || !kRun)
      kCnt <= '0;
    else if (kRise && kCnt != '1)
      kCnt <= kCnt + 1'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Properties
  AST_READ_BEATS: assert property (rdCmd |-> ##5 dataOutEn [*4])
    else $error("read burst not four beats after five cycles");
  AST_NO_STRAY_BEAT: assert property ($rose(dataOutEn) |-> $past(rdCmd, 5))
    else $error("read beat without read command");
  AST_OUT_OFF: assert property (rdCmd ##4 !rdCmd |-> ##5 !dataOutEn)
    else $error("outputs still on after burst end");
  AST_VALID_EQ_EN: assert property (dataValid == dataOutEn)
    else $error("data valid differs from output enable");
  AST_DLL_OFF_CLEARS: assert property (!dllOff_n |=> !dllLocked)
    else $error("lock kept through DLL disable");
  AST_KSTOP_CLEARS: assert property (!kRun |=> !dllLocked)
    else $error("lock kept through clock stop");
  AST_LOCK_COUNT: assert property ($rose(dllLocked) |-> kCnt == 12'h800)
    else $error("lock not at the 2048th K edge");
  AST_TAP_POWERUP: assert property ($fell(sys_rst) |-> tapInReset && !tdoOe)
    else $error("test port not in reset after reset");
  AST_TAP_QUIET: assert property (tapInReset |-> !tdoOe)
    else $error("test output driven while test port in reset");
  AST_TEST_PINS_IDLE: assert property (!tck && !tmsOe && !tdiOe)
    else $error("test pins driven by controller");

  CV_READ: cover property (rdCmd);
  CV_WRITE: cover property (kRise && !writeSel_n);
  CV_SEAMLESS: cover property (rdCmd ##4 rdCmd);
  CV_LOCK: cover property ($rose(dllLocked));
  CV_STOP: cover property ($fell(kRun));
endmodule

// ===== sim/test_burst4_ddr_sram_port.sv
// Self-checking bench: controller and device joined by the link.
// Assumes a 10 MHz clock; random traffic from a fixed seed.
`timescale 1ns/10ps
module test_burst4_ddr_sram_port;
  import bdsp_pkg::*;

  localparam bdsp_burst_t ONE = 72'h1;

  logic        clk;
  logic        sys_rst;
  logic        clockStop;
  logic        reqValid;
  logic        reqReady;
  logic        reqWrite;
  bdsp_addr_t  reqAddr;
  bdsp_burst_t reqWrData;
  bdsp_bmask_t reqMask_n;
  bdsp_burst_t rdData;
  logic        rdValid;
  logic        linkReady;
  logic        dllLocked;
  logic        tapInReset;
  int          miscompares;
  int          comparisons;
  bdsp_data_t  mem [DEPTH];
  bdsp_burst_t expQ [$];

  bdsp_link_if link ();

  bdsp_device bdsp_device_i (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .link       (link),
    .dllLocked  (dllLocked),
    .tapInReset (tapInReset)
  );

  bdsp_ctrl bdsp_ctrl_i (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .link      (link),
    .clockStop (clockStop),
    .reqValid  (reqValid),
    .reqReady  (reqReady),
    .reqWrite  (reqWrite),
    .reqAddr   (reqAddr),
    .reqWrData (reqWrData),
    .reqMask_n (reqMask_n),
    .rdData    (rdData),
    .rdValid   (rdValid),
    .linkReady (linkReady)
  );

  bdsp_link_checker checker_i (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .kRise      (link.kRise),
    .kRun       (link.kRun),
    .dllOff_n   (link.dllOff_n),
    .readSel_n  (link.readSel_n),
    .writeSel_n (link.writeSel_n),
    .dataOutEn  (link.dataOutEn),
    .dataValid  (link.dataValid),
    .tck        (link.tck),
    .tmsOe      (link.tmsOe),
    .tdiOe      (link.tdiOe),
    .tdoOe      (link.tdoOe),
    .dllLocked  (dllLocked),
    .tapInReset (tapInReset)
  );

  always #50 clk = ~clk;

  // ==========================================================
  // Checking and expectations
  task automatic chk(input bdsp_burst_t seen, input bdsp_burst_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic bdsp_burst_t rnd();
    logic [95:0] r;
    r = {$urandom(), $urandom(), $urandom()};
    return r[BURST*DATA_W-1:0];
  endfunction

  function automatic bdsp_burst_t expBurst(input bdsp_addr_t a);
    bdsp_burst_t r;
    for (int k = 0; k < BURST; k++)
      r[k*DATA_W +: DATA_W] = mem[{a, k[BEAT_W-1:0]}];
    return r;
  endfunction

  // Only bytes with an active mask bit change
  function automatic void applyWrite(input bdsp_addr_t a,
                                     input bdsp_burst_t d,
                                     input bdsp_bmask_t m);
    for (int k = 0; k < BURST; k++)
      for (int b = 0; b < NBYTES; b++)
        if (!m[k*NBYTES+b])
          mem[{a, k[BEAT_W-1:0]}][b*BYTE_W +: BYTE_W] =
            d[k*DATA_W+b*BYTE_W +: BYTE_W];
  endfunction

  // ==========================================================
  // Request port driving
  task automatic fail_now();
    miscompares++;
    test_done();
  endtask

  // Valid stays up after the take; the controller refuses for 3 clks
  task automatic issue(input logic wr, input bdsp_addr_t a,
                       input bdsp_burst_t d, input bdsp_bmask_t m);
    int n;
    n = 0;
    #1;
    reqValid = 1'h1;
    reqWrite = wr;
    reqAddr = a;
    reqWrData = d;
    reqMask_n = m;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (reqReady !== 1'h1 && n < 200);
    if (n >= 200)
      fail_now();
    if (wr)
      applyWrite(a, d, m);
    else
      expQ.push_back(expBurst(a));
  endtask

  task automatic idle(input int c);
    #1;
    reqValid = 1'h0;
    repeat (c) @(posedge clk);
  endtask

  task automatic waitLink();
    int n;
    n = 0;
    while (linkReady !== 1'h1 && n < 6000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000)
      fail_now();
  endtask

  task automatic drain();
    int n;
    n = 0;
    idle(1);
    while (expQ.size() != 0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (expQ.size() != 0)
      fail_now();
    idle(2);
  endtask

  always @(posedge clk)
  begin
    if (rdValid === 1'h1 && expQ.size() == 0)
      fail_now();
    else if (rdValid === 1'h1)
      chk(rdData, expQ.pop_front());
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 1'h0;
    sys_rst = 1'h1;
    clockStop = 1'h0;
    reqValid = 1'h0;
    reqWrite = 1'h0;
    reqAddr = '0;
    reqWrData = '0;
    reqMask_n = '1;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(89875));
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    @(posedge clk);
    chk(bdsp_burst_t'(tapInReset), ONE);
    chk(bdsp_burst_t'(link.tdoOe), '0);
    waitLink();
    chk(bdsp_burst_t'(dllLocked), ONE);
    for (int a = 0; a < 64; a++)
      issue(1'h1, 6'(a), rnd(), '0);
    // Read-back of a partly masked write, then of an all-masked write
    issue(1'h1, 6'h3F, rnd(), 8'hA5);
    issue(1'h0, 6'h3F, '0, '1);
    issue(1'h1, 6'h00, rnd(), 8'hFF);
    issue(1'h0, 6'h00, '0, '1);
    for (int i = 0; i < 300; i++)
      issue(1'($urandom_range(0, 1)), 6'($urandom_range(0, 7)), rnd(),
            8'($urandom()));
    drain();
    chk(bdsp_burst_t'(link.dataOutEn), '0);
    #1;
    clockStop = 1'h1;
    // Stop waits for write beats to finish; sample after it settles
    repeat (12) @(posedge clk);
    #1;
    chk(bdsp_burst_t'(dllLocked), '0);
    chk(bdsp_burst_t'(linkReady), '0);
    chk(bdsp_burst_t'(link.kRun), '0);
    clockStop = 1'h0;
    waitLink();
    chk(bdsp_burst_t'(dllLocked), ONE);
    for (int a = 0; a < 64; a++)
      issue(1'h0, 6'(a), '0, '1);
    drain();
    test_done();
  end
endmodule
